// *** src/alu_status_map.svh ***
// register offsets, field positions, reset values and address limits of the status block
`ifndef ALU_STATUS_MAP_SVH
`define ALU_STATUS_MAP_SVH

// register port offsets (4-bit register index)
`define REG_STATUS 4'h0
`define REG_BANK 4'h1
`define REG_PTR0_LO 4'h2
`define REG_PTR0_HI 4'h3
`define REG_PTR1_LO 4'h4
`define REG_PTR1_HI 4'h5
`define REG_PTR2_LO 4'h6
`define REG_PTR2_HI 4'h7
`define REG_ACCUM 4'h8
`define REG_CONFIG 4'h9

// status register field positions
`define ST_UNIMPL 7
`define ST_TIMEOUT 6
`define ST_PWRDOWN 5
`define ST_NEG 4
`define ST_OVF 3
`define ST_ZERO 2
`define ST_NIB 1
`define ST_CARRY 0

// config register field position
`define CFG_EXT_EN 0

// reset values
`define RST_ARITH 5'h00
`define RST_CAUSE 2'h3
`define RST_BYTE 8'h00
`define RST_PTR 12'h000

// data address of the status register inside the data map
`define STATUS_FILE_ADDR 12'hff0
// access bank split and indexed literal offset ceiling
`define ACCESS_SPLIT 8'h60
`define LIT_OFS_LIMIT 8'h5f
`define ACCESS_HI_BANK 4'hf
`define ACCESS_LO_BANK 4'h0

`endif

// *** src/alu_status_pkg.sv ***
// types shared by the status and data addressing block
package alu_status_pkg;

  // instruction classes presented to the block
  typedef enum logic [4:0] {
    op_nop = 5'h00,
    op_add_reg = 5'h01,
    op_add_lit = 5'h02,
    op_sub_reg = 5'h03,
    op_sub_lit = 5'h04,
    op_and = 5'h05,
    op_or = 5'h06,
    op_xor = 5'h07,
    op_clear = 5'h08,
    op_move_f = 5'h09,
    op_store_w = 5'h0a,
    op_move_full = 5'h0b,
    op_rot_right_c = 5'h0c,
    op_rot_left_c = 5'h0d,
    op_dec_adjust = 5'h0e,
    op_clear_watchdog = 5'h0f,
    op_halt = 5'h10,
    op_branch = 5'h11,
    op_move_lit = 5'h12
  } op_t;

  // indirect operand flavours
  typedef enum logic [2:0] {
    ind_plain = 3'h0,
    ind_post_inc = 3'h1,
    ind_post_dec = 3'h2,
    ind_pre_inc = 3'h3,
    ind_plus_w = 3'h4
  } ind_t;

endpackage

// *** src/alu_status_addr.sv ***
// arithmetic status flags, reset-cause bits and data operand address formation
//
// Operation
// - status bit 7 has no storage and always reads zero.
// - timeout flag set at power-up, clear-watchdog, halt; cleared by watchdog time-out.
// - power-down flag set at power-up and clear-watchdog; cleared by halt.
// - negative flag copies the result's most significant bit.
// - overflow flag set when signed result flips the sign bit, else cleared.
// - zero flag set when result is zero, cleared otherwise.
// - nibble carry records carry out of bit 3 for add and subtract.
// - carry records carry out of bit 7 for add and subtract.
// - subtraction adds the two's complement, so carries act as inverted borrows.
// - rotate through carry loads carry with the bit shifted out.
// - direct address uses bank value when access bit set, else access bank.
// - full-address move ignores the bank select value.
// - destination bit one writes the register, zero writes the accumulator.
// - instructions without destination bit use their fixed implicit target.
// - call and jump present a twenty-bit program address as target.
// - indexed literal offset mode exists only with extended set enabled.
// - indirect access uses pointers with increment, decrement or offset.
// - inherent instructions act globally or on one implicit register.
// - flag-affecting result aimed at status is dropped; flags update instead.
// - pointers hold twelve bits; upper four bits of high byte read zero.
// - post-increment uses the pointed location, then adds one to the pointer.
// - extended mode, access bit zero, address up to limit: offset plus third pointer.
`include "alu_status_map.svh"

module alu_status_addr #(
  parameter int ADDR_W = 12,
  parameter int PC_W = 20
) (
  input wire logic ref_clk_in, // 20 MHz core clock
  input wire logic sys_rst_in, // synchronous reset, power-up
  input wire logic [3:0] reg_addr_in, // register index
  input wire logic [7:0] reg_wdata_in, // register write data
  input wire logic reg_wr_in, // register write strobe
  input wire logic reg_rd_in, // register read strobe
  output logic [7:0] reg_rdata_out, // read data, cycle after strobe
  input wire logic op_valid_in, // execute one instruction
  input wire alu_status_pkg::op_t op_code_in, // instruction class
  input wire logic [7:0] file_addr_in, // eight-bit file address
  input wire logic access_sel_in, // 1: bank select, 0: access bank
  input wire logic dest_sel_in, // 1: register, 0: accumulator
  input wire logic indirect_in, // operand is an indirect operand
  input wire logic [1:0] ptr_sel_in, // pointer number 0..2
  input wire alu_status_pkg::ind_t ind_kind_in, // indirect operand flavour
  input wire logic [ADDR_W-1:0] full_addr_in, // full destination address
  input wire logic [7:0] operand_in, // file data or literal
  input wire logic [PC_W-1:0] target_in, // program address of a branch
  input wire logic wdt_timeout_in, // watchdog time-out pulse
  output logic [ADDR_W-1:0] mem_addr_out, // data write address
  output logic [7:0] mem_wdata_out, // data write value
  output logic mem_we_out, // data write pulse
  output logic [PC_W-1:0] branch_target_out, // branch target
  output logic branch_out, // branch pulse
  output logic wdt_clear_out, // watchdog restart pulse
  output logic halt_out // halt request pulse
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (ADDR_W != 12) begin : g_chk_addr
    $error("ADDR_W must be 12");
  end
  if (PC_W != 20) begin : g_chk_pc
    $error("PC_W must be 20");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic flag_n;
  logic flag_ov;
  logic flag_z;
  logic flag_dc;
  logic flag_c;
  logic timeout_flag;
  logic powerdown_flag;
  logic [3:0] bank_select_value;
  logic [ADDR_W-1:0] ptr0;
  logic [ADDR_W-1:0] ptr1;
  logic [ADDR_W-1:0] ptr2;
  logic [7:0] accum;
  logic extended_set_enable;

  logic exec;
  alu_status_pkg::op_t op;
  assign exec = op_valid_in;
  assign op = op_code_in;

  // ----------------------------------------
  // operand address formation
  // ----------------------------------------
  logic [ADDR_W-1:0] ptr_cur;
  logic [ADDR_W-1:0] ind_ea;
  logic [ADDR_W-1:0] ptr_next;
  logic ptr_changes;
  logic [ADDR_W-1:0] ea;
  logic lit_ofs_mode;

  always_comb begin
    case (ptr_sel_in)
      2'd0: ptr_cur = ptr0;
      2'd1: ptr_cur = ptr1;
      default: ptr_cur = ptr2;
    endcase
  end

  always_comb begin
    ind_ea = ptr_cur;
    ptr_next = ptr_cur;
    ptr_changes = 1'b0;
    case (ind_kind_in)
      alu_status_pkg::ind_post_inc: begin
        ptr_next = ptr_cur + 12'h001;
        ptr_changes = 1'b1;
      end
      alu_status_pkg::ind_post_dec: begin
        ptr_next = ptr_cur - 12'h001;
        ptr_changes = 1'b1;
      end
      alu_status_pkg::ind_pre_inc: begin
        ind_ea = ptr_cur + 12'h001;
        ptr_next = ind_ea;
        ptr_changes = 1'b1;
      end
      alu_status_pkg::ind_plus_w: begin
        ind_ea = ptr_cur + {{4{accum[7]}}, accum};
      end
      default: begin
        ind_ea = ptr_cur;
      end
    endcase
  end

  // indexed literal offset only with the extended set switched on
  assign lit_ofs_mode = extended_set_enable && !access_sel_in &&
                        (file_addr_in <= `LIT_OFS_LIMIT);

  always_comb begin
    if (op == alu_status_pkg::op_move_full) begin
      ea = full_addr_in;
    end else if (indirect_in) begin
      ea = ind_ea;
    end else if (lit_ofs_mode) begin
      ea = ptr2 + {4'h0, file_addr_in};
    end else if (access_sel_in) begin
      ea = {bank_select_value, file_addr_in};
    end else if (file_addr_in < `ACCESS_SPLIT) begin
      ea = {`ACCESS_LO_BANK, file_addr_in};
    end else begin
      ea = {`ACCESS_HI_BANK, file_addr_in};
    end
  end

  // ----------------------------------------
  // arithmetic and logic unit
  // ----------------------------------------
  logic [7:0] add_b;
  logic add_cin;
  logic [7:0] add_a;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] res;
  logic res_c;
  logic upd_c;
  logic upd_dc;
  logic upd_ov;
  logic upd_zn;
  logic to_mem;
  logic to_acc;
  logic [8:0] daw_lo;
  logic [8:0] daw_hi;

  always_comb begin
    add_a = operand_in;
    add_b = accum;
    add_cin = 1'b0;
    if (op == alu_status_pkg::op_sub_reg || op == alu_status_pkg::op_sub_lit) begin
      add_b = ~accum;
      add_cin = 1'b1;
    end
    sum9 = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_cin};
    sum5 = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
  end

  // decimal adjust of the accumulator
  always_comb begin
    daw_lo = {1'b0, accum};
    if (accum[3:0] > 4'h9 || flag_dc) begin
      daw_lo = {1'b0, accum} + 9'h006;
    end
    daw_hi = daw_lo;
    if (daw_lo[7:4] > 4'h9 || flag_c || daw_lo[8]) begin
      daw_hi = daw_lo + 9'h060;
    end
  end

  always_comb begin
    res = operand_in;
    res_c = flag_c;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_ov = 1'b0;
    upd_zn = 1'b0;
    to_mem = 1'b0;
    to_acc = 1'b0;
    case (op)
      alu_status_pkg::op_add_reg, alu_status_pkg::op_sub_reg: begin
        res = sum9[7:0];
        res_c = sum9[8];
        {upd_c, upd_dc, upd_ov, upd_zn} = 4'hf;
        to_mem = dest_sel_in;
        to_acc = !dest_sel_in;
      end
      alu_status_pkg::op_add_lit, alu_status_pkg::op_sub_lit: begin
        res = sum9[7:0];
        res_c = sum9[8];
        {upd_c, upd_dc, upd_ov, upd_zn} = 4'hf;
        to_acc = 1'b1;
      end
      alu_status_pkg::op_and: begin
        res = operand_in & accum;
        upd_zn = 1'b1;
        to_mem = dest_sel_in;
        to_acc = !dest_sel_in;
      end
      alu_status_pkg::op_or: begin
        res = operand_in | accum;
        upd_zn = 1'b1;
        to_mem = dest_sel_in;
        to_acc = !dest_sel_in;
      end
      alu_status_pkg::op_xor: begin
        res = operand_in ^ accum;
        upd_zn = 1'b1;
        to_mem = dest_sel_in;
        to_acc = !dest_sel_in;
      end
      alu_status_pkg::op_move_f: begin
        res = operand_in;
        upd_zn = 1'b1;
        to_mem = dest_sel_in;
        to_acc = !dest_sel_in;
      end
      alu_status_pkg::op_rot_right_c: begin
        res = {flag_c, operand_in[7:1]};
        res_c = operand_in[0];
        upd_c = 1'b1;
        upd_zn = 1'b1;
        to_mem = dest_sel_in;
        to_acc = !dest_sel_in;
      end
      alu_status_pkg::op_rot_left_c: begin
        res = {operand_in[6:0], flag_c};
        res_c = operand_in[7];
        upd_c = 1'b1;
        upd_zn = 1'b1;
        to_mem = dest_sel_in;
        to_acc = !dest_sel_in;
      end
      alu_status_pkg::op_clear: begin
        res = 8'h00;
        to_mem = 1'b1;
      end
      alu_status_pkg::op_store_w: begin
        res = accum;
        to_mem = 1'b1;
      end
      alu_status_pkg::op_move_full: begin
        res = operand_in;
        to_mem = 1'b1;
      end
      alu_status_pkg::op_move_lit: begin
        res = operand_in;
        to_acc = 1'b1;
      end
      alu_status_pkg::op_dec_adjust: begin
        res = daw_hi[7:0];
        res_c = daw_hi[8] | flag_c;
        upd_c = 1'b1;
        to_acc = 1'b1;
      end
      default: begin
        res = operand_in;
      end
    endcase
  end

  // only the zero flag moves on a register clear
  logic upd_z_only;
  logic flag_op;
  logic hits_status;
  logic mem_write;
  logic status_store;
  assign upd_z_only = (op == alu_status_pkg::op_clear);
  assign flag_op = upd_c | upd_dc | upd_ov | upd_zn | upd_z_only;
  assign hits_status = (ea == `STATUS_FILE_ADDR);
  assign mem_write = exec && to_mem && !hits_status;
  assign status_store = exec && to_mem && hits_status && !flag_op;

  // ----------------------------------------
  // arithmetic flags
  // ----------------------------------------
  logic bus_status_wr;
  assign bus_status_wr = reg_wr_in && (reg_addr_in == `REG_STATUS);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      {flag_n, flag_ov, flag_z, flag_dc, flag_c} <= `RST_ARITH;
    end else if (exec && flag_op) begin
      if (upd_zn) begin
        flag_n <= res[7];
      end
      if (upd_zn || upd_z_only) begin
        flag_z <= (res == 8'h00);
      end
      if (upd_ov) begin
        flag_ov <= (add_a[7] == add_b[7]) && (sum9[7] != add_a[7]);
      end
      if (upd_dc) begin
        flag_dc <= sum5[4];
      end
      if (upd_c) begin
        flag_c <= res_c;
      end
    end else if (status_store) begin
      flag_n <= res[`ST_NEG];
      flag_ov <= res[`ST_OVF];
      flag_z <= res[`ST_ZERO];
      flag_dc <= res[`ST_NIB];
      flag_c <= res[`ST_CARRY];
    end else if (bus_status_wr) begin
      flag_n <= reg_wdata_in[`ST_NEG];
      flag_ov <= reg_wdata_in[`ST_OVF];
      flag_z <= reg_wdata_in[`ST_ZERO];
      flag_dc <= reg_wdata_in[`ST_NIB];
      flag_c <= reg_wdata_in[`ST_CARRY];
    end
  end

  // ----------------------------------------
  // reset-cause flags and inherent controls
  // ----------------------------------------
  logic is_clear_watchdog_instruction;
  logic is_halt;
  assign is_clear_watchdog_instruction = exec && (op == alu_status_pkg::op_clear_watchdog);
  assign is_halt = exec && (op == alu_status_pkg::op_halt);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      {timeout_flag, powerdown_flag} <= `RST_CAUSE;
    end else begin
      if (wdt_timeout_in) begin
        timeout_flag <= 1'b0;
      end else if (is_clear_watchdog_instruction || is_halt) begin
        timeout_flag <= 1'b1;
      end
      if (is_clear_watchdog_instruction) begin
        powerdown_flag <= 1'b1;
      end else if (is_halt) begin
        powerdown_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wdt_clear_out <= 1'b0;
      halt_out <= 1'b0;
    end else begin
      wdt_clear_out <= is_clear_watchdog_instruction;
      halt_out <= is_halt;
    end
  end

  // ----------------------------------------
  // accumulator, bank select and config
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      accum <= `RST_BYTE;
    end else if (exec && to_acc) begin
      accum <= res;
    end else if (reg_wr_in && reg_addr_in == `REG_ACCUM) begin
      accum <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      bank_select_value <= 4'h0;
      extended_set_enable <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `REG_BANK) begin
        bank_select_value <= reg_wdata_in[3:0];
      end
      if (reg_addr_in == `REG_CONFIG) begin
        extended_set_enable <= reg_wdata_in[`CFG_EXT_EN];
      end
    end
  end

  // ----------------------------------------
  // pointer registers
  // ----------------------------------------
  logic ptr_step;
  assign ptr_step = exec && indirect_in && ptr_changes &&
                    (op != alu_status_pkg::op_move_full);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ptr0 <= `RST_PTR;
      ptr1 <= `RST_PTR;
      ptr2 <= `RST_PTR;
    end else if (ptr_step) begin
      case (ptr_sel_in)
        2'd0: ptr0 <= ptr_next;
        2'd1: ptr1 <= ptr_next;
        default: ptr2 <= ptr_next;
      endcase
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `REG_PTR0_LO: ptr0[7:0] <= reg_wdata_in;
        `REG_PTR0_HI: ptr0[11:8] <= reg_wdata_in[3:0];
        `REG_PTR1_LO: ptr1[7:0] <= reg_wdata_in;
        `REG_PTR1_HI: ptr1[11:8] <= reg_wdata_in[3:0];
        `REG_PTR2_LO: ptr2[7:0] <= reg_wdata_in;
        `REG_PTR2_HI: ptr2[11:8] <= reg_wdata_in[3:0];
        default: ptr0 <= ptr0;
      endcase
    end
  end

  // ----------------------------------------
  // data write and branch outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      mem_addr_out <= `RST_PTR;
      mem_wdata_out <= `RST_BYTE;
      mem_we_out <= 1'b0;
    end else begin
      mem_we_out <= mem_write;
      if (mem_write) begin
        mem_addr_out <= ea;
        mem_wdata_out <= res;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      branch_target_out <= '0;
      branch_out <= 1'b0;
    end else begin
      branch_out <= exec && (op == alu_status_pkg::op_branch);
      if (exec && op == alu_status_pkg::op_branch) begin
        branch_target_out <= target_in;
      end
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  logic [7:0] status_view;
  assign status_view = {1'b0, timeout_flag, powerdown_flag,
                        flag_n, flag_ov, flag_z, flag_dc, flag_c};

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= `RST_BYTE;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `REG_STATUS: reg_rdata_out <= status_view;
        `REG_BANK: reg_rdata_out <= {4'h0, bank_select_value};
        `REG_PTR0_LO: reg_rdata_out <= ptr0[7:0];
        `REG_PTR0_HI: reg_rdata_out <= {4'h0, ptr0[11:8]};
        `REG_PTR1_LO: reg_rdata_out <= ptr1[7:0];
        `REG_PTR1_HI: reg_rdata_out <= {4'h0, ptr1[11:8]};
        `REG_PTR2_LO: reg_rdata_out <= ptr2[7:0];
        `REG_PTR2_HI: reg_rdata_out <= {4'h0, ptr2[11:8]};
        `REG_ACCUM: reg_rdata_out <= accum;
        `REG_CONFIG: reg_rdata_out <= {7'h00, extended_set_enable};
        default: reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

endmodule

// *** bench/alu_status_addr_monitor.sv ***
// port-level assertions for the status and data addressing block
module alu_status_addr_monitor #(
  parameter int ADDR_W = 12,
  parameter int PC_W = 20
) (
  input wire logic ref_clk_in, // core clock
  input wire logic sys_rst_in, // sync reset
  input wire logic [3:0] reg_addr_in, // register index
  input wire logic reg_wr_in, // write strobe
  input wire logic reg_rd_in, // read strobe
  input wire logic [7:0] reg_rdata_out, // read data
  input wire logic op_valid_in, // instruction valid
  input wire alu_status_pkg::op_t op_code_in, // instruction class
  input wire logic [ADDR_W-1:0] full_addr_in, // full address
  input wire logic [PC_W-1:0] target_in, // branch target in
  input wire logic wdt_timeout_in, // watchdog time-out
  input wire logic [ADDR_W-1:0] mem_addr_out, // write address
  input wire logic mem_we_out, // write pulse
  input wire logic [PC_W-1:0] branch_target_out, // branch target out
  input wire logic branch_out, // branch pulse
  input wire logic wdt_clear_out, // watchdog restart
  input wire logic halt_out // halt pulse
);
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  //----------------------------------------
  // sequences
  //----------------------------------------
  sequence status_read;
    reg_rd_in && !reg_wr_in && reg_addr_in == 4'h0;
  endsequence
  sequence quiet_timeout;
    wdt_timeout_in ##1 !op_valid_in ##1 (status_read and !op_valid_in);
  endsequence
  a_top_bit_zero: assert property (status_read |=> reg_rdata_out[7] == 1'b0)
    else $error("status top bit not zero");
  a_timeout_clears: assert property (quiet_timeout |=> reg_rdata_out[6] == 1'b0)
    else $error("timeout flag not cleared");
  a_clear_wdt_pulse: assert property (op_valid_in && op_code_in == alu_status_pkg::op_clear_watchdog
    |=> wdt_clear_out)
    else $error("watchdog restart missing");
  a_halt_pulse: assert property (op_valid_in && op_code_in == alu_status_pkg::op_halt
    |=> halt_out)
    else $error("halt pulse missing");
  a_halt_cause: assert property (halt_out |-> $past(op_valid_in && op_code_in == alu_status_pkg::op_halt))
    else $error("halt pulse without halt");
  a_branch_target: assert property (op_valid_in && op_code_in == alu_status_pkg::op_branch
    |=> branch_out && branch_target_out == $past(target_in))
    else $error("branch target wrong");
  a_full_move_addr: assert property (op_valid_in && op_code_in == alu_status_pkg::op_move_full
    && full_addr_in != 12'hff0 |=> mem_we_out && mem_addr_out == $past(full_addr_in))
    else $error("full move address wrong");
  a_no_status_write: assert property (mem_we_out |-> mem_addr_out != 12'hff0)
    else $error("write reached status address");
  a_write_has_op: assert property (mem_we_out |-> $past(op_valid_in))
    else $error("write without instruction");
endmodule

bind alu_status_addr alu_status_addr_monitor #(.ADDR_W(ADDR_W), .PC_W(PC_W)) i_mon (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .op_valid_in(op_valid_in), .op_code_in(op_code_in), .full_addr_in(full_addr_in),
  .target_in(target_in), .wdt_timeout_in(wdt_timeout_in), .mem_addr_out(mem_addr_out),
  .mem_we_out(mem_we_out), .branch_target_out(branch_target_out), .branch_out(branch_out),
  .wdt_clear_out(wdt_clear_out), .halt_out(halt_out)
);

// *** bench/alu_status_and_data_addressing_tb.sv ***
// self-checking bench for the status and data addressing block
module alu_status_and_data_addressing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr, rd, ov, acc, dst, ind, wto, we, bo, wc, ho;
  logic [3:0] ra;
  logic [7:0] wd, rdata, fa, opnd, mw, v, w, o, f, r;
  logic [1:0] ps, cause;
  logic [11:0] full, ma;
  logic [19:0] tgt, bt;
  logic [4:0] fl, c;
  logic d, m;
  alu_status_pkg::op_t code;
  alu_status_pkg::ind_t ik;
  int fail_count, check_count, seed, i;
  logic [4:0] tbl [9] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0c, 5'h0d};

  alu_status_addr i_alu_status_addr (
    .ref_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .op_valid_in(ov),
    .op_code_in(code), .file_addr_in(fa), .access_sel_in(acc), .dest_sel_in(dst),
    .indirect_in(ind), .ptr_sel_in(ps), .ind_kind_in(ik), .full_addr_in(full),
    .operand_in(opnd), .target_in(tgt), .wdt_timeout_in(wto), .mem_addr_out(ma),
    .mem_wdata_out(mw), .mem_we_out(we), .branch_target_out(bt), .branch_out(bo),
    .wdt_clear_out(wc), .halt_out(ho)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  //----------------------------------------
  // bench tasks and reference function
  //----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] dv);
    @(posedge clk);
    ra <= a; wd <= dv; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    ra <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic op(input logic [4:0] oc, input logic [7:0] fv, ovl, input logic a, dv, iv);
    @(posedge clk);
    code <= alu_status_pkg::op_t'(oc); fa <= fv; opnd <= ovl;
    acc <= a; dst <= dv; ind <= iv; ov <= 1'b1;
    @(posedge clk);
    ov <= 1'b0;
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // returns {n, ov, z, dc, c, result}; subtracts add the two's complement of w
  function automatic logic [12:0] alu(input logic [4:0] k, input logic [7:0] a, wv,
                                      input logic [4:0] g);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] b, q;
    logic ci;
    ci = (k == 5'h03 || k == 5'h04);
    b = ci ? ~wv : wv;
    s = a + b + ci;
    h = a[3:0] + b[3:0] + ci;
    q = s[7:0];
    if (k == 5'h05) q = a & wv;
    if (k == 5'h06) q = a | wv;
    if (k == 5'h07) q = a ^ wv;
    if (k == 5'h0c) begin
      q = {g[0], a[7:1]};
      s[8] = a[0];
    end
    if (k == 5'h0d) begin
      q = {a[6:0], g[0]};
      s[8] = a[7];
    end
    if (k < 5'h05) g = {q[7], a[7] == b[7] && q[7] != a[7], q == 8'h00, h[4], s[8]};
    else if (k < 5'h08) g = {q[7], g[3], q == 8'h00, g[1:0]};
    else g = {q[7], g[3], q == 8'h00, g[1], s[8]};
    return {g, q};
  endfunction
  //----------------------------------------
  // main sequence
  //----------------------------------------
  initial begin
    seed = 21;
    rst = 1'b1; wr = 1'b0; rd = 1'b0; ov = 1'b0; ra = 4'h0; wd = 8'h00;
    code = alu_status_pkg::op_nop; fa = 8'h00; acc = 1'b0; dst = 1'b0; ind = 1'b0;
    ps = 2'h0; ik = alu_status_pkg::ind_post_inc; full = 12'h5a3; opnd = 8'h00;
    tgt = 20'h0_0000; wto = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cause = 2'h3;
    rreg(4'h0); chk(v, 8'h60);
    rreg(4'hf); chk(v, 8'h00);
    wreg(4'h0, 8'hff); fl = 5'h1f;
    rreg(4'h0); chk(v, 8'h7f);
    wreg(4'h1, 8'h03);
    wreg(4'h2, 8'hff); wreg(4'h3, 8'hf1);
    rreg(4'h3); chk(v, 8'h01);
    op(5'h08, 8'h00, 8'h00, 1'b0, 1'b1, 1'b1);
    chk(we, 1'b1); chk(ma, 12'h1ff);
    rreg(4'h2); chk(v, 8'h00);
    rreg(4'h3); chk(v, 8'h02);
    for (i = 0; i < 60; i++) begin
      w = 8'($random(seed)); o = 8'($random(seed)); f = 8'($random(seed));
      d = 1'($random(seed)); c = tbl[$unsigned($random(seed)) % 9];
      if (i == 0) begin w = 8'h01; o = 8'h7f; c = 5'h01; end
      if (i == 1) begin w = 8'h05; o = 8'h05; c = 5'h03; end
      if (i == 2) begin w = 8'h80; o = 8'h80; c = 5'h02; end
      wreg(4'h8, w);
      op(c, f, o, 1'b1, d, 1'b0);
      {fl, r} = alu(c, o, w, fl);
      m = d && c != 5'h02 && c != 5'h04;
      chk(we, m);
      if (m) begin
        chk(ma, {4'h3, f});
        chk(mw, r);
      end
      rreg(4'h0); chk(v, {1'b0, cause, fl});
      chk(v[4], r[7]);
      chk(v[2], r == 8'h00);
      if (c < 5'h05) chk(v[1], fl[1]);
      if (c < 5'h05) chk(v[0], fl[0]);
      if (c > 5'h0b) chk(v[0], c == 5'h0c ? o[0] : o[7]);
      rreg(4'h8); chk(v, m ? w : r);
    end
    op(5'h10, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0); chk(ho, 1'b1);
    cause = 2'h2;
    rreg(4'h0); chk(v, {1'b0, cause, fl});
    chk(v[4:0], fl);
    @(posedge clk); wto <= 1'b1;
    @(posedge clk); wto <= 1'b0;
    cause = 2'h0;
    rreg(4'h0); chk(v, {1'b0, cause, fl});
    op(5'h0f, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0); chk(wc, 1'b1);
    cause = 2'h3;
    rreg(4'h0); chk(v, {1'b0, cause, fl});
    op(5'h08, 8'hf0, 8'h00, 1'b0, 1'b1, 1'b0); chk(we, 1'b0);
    fl[2] = 1'b1;
    rreg(4'h0); chk(v, {1'b0, cause, fl});
    op(5'h0b, 8'h00, 8'h3c, 1'b1, 1'b1, 1'b0); chk(ma, 12'h5a3);
    chk(mw, 8'h3c);
    wreg(4'h9, 8'h01); wreg(4'h6, 8'h00); wreg(4'h7, 8'h01);
    op(5'h08, 8'h5f, 8'h00, 1'b0, 1'b1, 1'b0); chk(ma, 12'h15f);
    op(5'h08, 8'h60, 8'h00, 1'b0, 1'b1, 1'b0); chk(ma, 12'hf60);
    wreg(4'h9, 8'h00);
    op(5'h08, 8'h5f, 8'h00, 1'b0, 1'b1, 1'b0); chk(ma, 12'h05f);
    tgt <= 20'($random(seed));
    op(5'h11, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0); chk(bo, 1'b1);
    chk(bt, tgt);
    // decimal adjust of 9a gives 00 with carry, then a store of zero into status
    wreg(4'h0, 8'h00); fl = 5'h00;
    op(5'h12, 8'h00, 8'h9a, 1'b0, 1'b0, 1'b0);
    op(5'h0e, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
    rreg(4'h8); chk(v, 8'h00);
    rreg(4'h0); chk(v, {1'b0, cause, 5'h01});
    op(5'h0a, 8'hf0, 8'h00, 1'b0, 1'b0, 1'b0); chk(we, 1'b0);
    rreg(4'h0); chk(v, {1'b0, cause, 5'h00});
    // pointer 1 starts at zero: pre-increment, post-decrement, plus accumulator
    ik <= alu_status_pkg::ind_pre_inc; ps <= 2'h1;
    op(5'h08, 8'h00, 8'h00, 1'b0, 1'b1, 1'b1); chk(ma, 12'h001);
    ik <= alu_status_pkg::ind_post_dec;
    op(5'h08, 8'h00, 8'h00, 1'b0, 1'b1, 1'b1); chk(ma, 12'h001);
    rreg(4'h4); chk(v, 8'h00);
    wreg(4'h8, 8'hff); ik <= alu_status_pkg::ind_plus_w;
    op(5'h08, 8'h00, 8'h00, 1'b0, 1'b1, 1'b1); chk(ma, 12'hfff);
    tally_and_finish;
  end

  initial begin
    #2_000_000;
    fail_count++;
    tally_and_finish;
  end
endmodule
